/* File: design/sce_top.sv */
`include "sce_consts.svh"
`default_nettype none

// Contract
// - flags record only that a change occurred; levels come from live status
// - writing one to a flag clears it; zero leaves it alone
// - writing one to a force bit sets the matching flag
// - reset clears every flag to zero
// - leaving card reset re-sets the status flag if status is still asserted and the detect flags if detect levels are low
// - interrupt raised when enabled and any unmasked flag is set
// - flag and enable bits 31 to 4 read zero and ignore writes
// - flag 3 sets when the powered level changes
// - flags 2 and 1 set when detect two or detect one level changes
// - flag 0 sets on rising edge for cardbus, both edges for 16-bit
// - enables gate only the interrupt; flags latch regardless
// - enable bit 3 enables the power event; reset zero
// - detect enable pair 00 disables, 11 enables; reset 00
// - enable bit 0 enables the card status event; reset zero
// - live status is read-only, supply capability bits Y, X and 3 merged with forced bits
// - voltage and card type bits update only on card insertion
// - detect levels frozen during card identification
// - detect bits read one when pin high, zero when low
// - bit 3 shows socket powered, bit 0 mirrors card status line
module sce_top (
    // clock and reset
    input  wire logic                  clock_in,
    input  wire logic                  reset_in,
    // register access
    input  wire sce_pkg::sce_req_s     reg_req_in,
    output var  logic [31:0]           reg_rdata_out,
    output var  logic                  reg_rvalid_out,
    // socket pins and power state
    input  wire sce_pkg::sce_pins_s    pins_in,
    input  wire sce_pkg::sce_caps_s    card_caps_in,
    // same-clock socket control
    input  wire logic                  card_reset_in,
    input  wire logic                  identify_busy_in,
    input  wire logic                  card_is_cardbus_in,
    input  wire logic                  interrupts_enable_in,
    // interrupt request
    output var  logic                  status_change_interrupt_out
);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // set wins over clear so an event in the clearing cycle survives
    function automatic logic [3:0] next_sticky(input logic [3:0] cur,
                                               input logic [3:0] set,
                                               input logic [3:0] clr);
        next_sticky = (cur & ~clr) | set;
    endfunction

    function automatic logic addr_hit(input sce_pkg::sce_req_s req,
                                      input logic [7:0] off);
        addr_hit = (req.addr == off);
    endfunction

    // detect pair gates both detect flags; 01 and 10 act as disabled
    function automatic logic [3:0] gate_of(input logic [3:0] en);
        logic both;
        both    = en[`SCE_BIT_DET2] & en[`SCE_BIT_DET1];
        gate_of = {en[`SCE_BIT_POWER], both, both, en[`SCE_BIT_STATUS]};
    endfunction

    // ----------------------------------------
    // signals
    // ----------------------------------------
    sce_pkg::sce_pins_s pins_sync;
    sce_pkg::sce_pins_s live;
    sce_pkg::sce_pins_s next_live;
    sce_pkg::sce_caps_s caps;
    sce_pkg::sce_caps_s caps_meta;
    sce_pkg::sce_caps_s caps_sync;
    logic [3:0]         flags;
    logic [3:0]         enable;
    logic [2:0]         forced_caps;
    logic               card_reset_prev;
    logic [3:0]         hw_set;
    logic [3:0]         release_set;
    logic [3:0]         force_set;
    logic [3:0]         clear_bits;
    logic [3:0]         next_flags;
    logic               insertion;
    logic               reset_release;
    logic               wr_flags;
    logic               wr_enable;
    logic               wr_force;
    logic [31:0]        live_word;

    // ----------------------------------------
    // pin synchroniser
    // ----------------------------------------
    sce_sync i_sce_sync (
        .clock_in (clock_in),
        .reset_in (reset_in),
        .pins_in  (pins_in),
        .pins_out (pins_sync)
    );

    // ----------------------------------------
    // write decode
    // ----------------------------------------
    assign wr_flags  = reg_req_in.write & addr_hit(reg_req_in, `SCE_OFF_FLAGS);
    assign wr_enable = reg_req_in.write & addr_hit(reg_req_in, `SCE_OFF_ENABLE);
    assign wr_force  = reg_req_in.write & addr_hit(reg_req_in, `SCE_OFF_FORCE);

    // ----------------------------------------
    // live levels
    // ----------------------------------------
    always_comb begin
        next_live             = pins_sync;
        next_live.detect_two  = identify_busy_in ? live.detect_two
                                                 : pins_sync.detect_two;
        next_live.detect_one  = identify_busy_in ? live.detect_one
                                                 : pins_sync.detect_one;
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            live <= `SCE_PINS_RST;
        end else begin
            live <= next_live;
        end
    end

    // ----------------------------------------
    // event detection
    // ----------------------------------------
    // a flag only notes that a level moved; software reads live status
    always_comb begin
        hw_set                  = 4'h0;
        hw_set[`SCE_BIT_POWER]  = next_live.powered ^ live.powered;
        hw_set[`SCE_BIT_DET2]   = next_live.detect_two ^ live.detect_two;
        hw_set[`SCE_BIT_DET1]   = next_live.detect_one ^ live.detect_one;
        if (card_is_cardbus_in) begin
            hw_set[`SCE_BIT_STATUS] = next_live.card_status & ~live.card_status;
        end else begin
            hw_set[`SCE_BIT_STATUS] = next_live.card_status ^ live.card_status;
        end
        // status line is not trusted while the card is held in reset
        if (card_reset_in) begin
            hw_set[`SCE_BIT_STATUS] = 1'b0;
        end
    end

    assign reset_release = card_reset_prev & ~card_reset_in;

    // still-asserted status and low detect levels after card reset are reported again
    always_comb begin
        release_set                  = 4'h0;
        release_set[`SCE_BIT_STATUS] = reset_release & live.card_status;
        release_set[`SCE_BIT_DET2]   = reset_release & ~live.detect_two;
        release_set[`SCE_BIT_DET1]   = reset_release & ~live.detect_one;
    end

    assign force_set  = wr_force ? reg_req_in.data[3:0] : 4'h0;
    assign clear_bits = wr_flags ? reg_req_in.data[3:0] : 4'h0;
    assign next_flags = next_sticky(flags, hw_set | release_set | force_set,
                                    clear_bits);

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            card_reset_prev <= 1'b0;
        end else begin
            card_reset_prev <= card_reset_in;
        end
    end

    // ----------------------------------------
    // flag register
    // ----------------------------------------
    // enables never enter here, so masked events still latch
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            flags <= `SCE_FLAGS_RST;
        end else begin
            flags <= next_flags;
        end
    end

    // ----------------------------------------
    // enable register
    // ----------------------------------------
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            enable <= `SCE_ENABLE_RST;
        end else if (wr_enable) begin
            enable <= reg_req_in.data[3:0];
        end
    end

    // ----------------------------------------
    // card capabilities
    // ----------------------------------------
    // caps pins sit still around insertion, but they still cross into this clock
    always_ff @(posedge clock_in) begin
        caps_meta <= card_caps_in;
        caps_sync <= caps_meta;
    end

    // insertion: both detect levels reach low after not both low
    assign insertion = ~next_live.detect_two & ~next_live.detect_one
                     & (live.detect_two | live.detect_one);

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            caps <= `SCE_CAPS_RST;
        end else if (insertion) begin
            caps <= caps_sync;
        end
    end

    // forced supply bits last until the next insertion
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            forced_caps <= `SCE_FORCE_RST;
        end else if (insertion) begin
            forced_caps <= `SCE_FORCE_RST;
        end else if (wr_force) begin
            forced_caps <= forced_caps
                         | reg_req_in.data[`SCE_BIT_CAP_Y:`SCE_BIT_CAP_3];
        end
    end

    // ----------------------------------------
    // live status word
    // ----------------------------------------
    always_comb begin
        live_word                                  = `SCE_WORD_ZERO;
        live_word[29:28]                           = `SCE_SOCK_CAPS;
        live_word[`SCE_BIT_CAP_Y]                  = caps.volt_y | forced_caps[2];
        live_word[`SCE_BIT_CAP_X]                  = caps.volt_x | forced_caps[1];
        live_word[`SCE_BIT_CAP_3]                  = caps.volt_3 | forced_caps[0];
        live_word[`SCE_BIT_CAP_5]                  = caps.volt_5;
        live_word[`SCE_BIT_CBUS]                   = caps.cardbus;
        live_word[`SCE_BIT_B16]                    = caps.bit16;
        live_word[`SCE_BIT_POWER:`SCE_BIT_STATUS]  = live;
    end

    // ----------------------------------------
    // read port
    // ----------------------------------------
    // writes to the live address are ignored, it has no storage
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            reg_rdata_out  <= `SCE_WORD_ZERO;
            reg_rvalid_out <= 1'b0;
        end else begin
            reg_rvalid_out <= reg_req_in.read;
            if (!reg_req_in.read) begin
                reg_rdata_out <= `SCE_WORD_ZERO;
            end else if (addr_hit(reg_req_in, `SCE_OFF_FLAGS)) begin
                reg_rdata_out <= {28'h0000000, flags};
            end else if (addr_hit(reg_req_in, `SCE_OFF_ENABLE)) begin
                reg_rdata_out <= {28'h0000000, enable};
            end else if (addr_hit(reg_req_in, `SCE_OFF_LIVE)) begin
                reg_rdata_out <= live_word;
            end else begin
                reg_rdata_out <= `SCE_WORD_ZERO;
            end
        end
    end

    // ----------------------------------------
    // interrupt request
    // ----------------------------------------
    // stale flags fire at once when enabled; software clears them first
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            status_change_interrupt_out <= 1'b0;
        end else begin
            status_change_interrupt_out <= interrupts_enable_in
                                         & |(flags & gate_of(enable));
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (reset_in);

    sequence s_clear_write(int b);
        wr_flags && reg_req_in.data[b] && !(hw_set[b] || release_set[b] || force_set[b]);
    endsequence

    a_flag_clear: assert property (
        s_clear_write(`SCE_BIT_POWER) |=> !flags[`SCE_BIT_POWER])
        else $error("power flag not cleared by write of one");

    a_zero_write_keeps: assert property (
        (wr_flags && !reg_req_in.data[`SCE_BIT_POWER] && flags[`SCE_BIT_POWER])
        |=> flags[`SCE_BIT_POWER])
        else $error("write of zero disturbed power flag");

    a_force_sets: assert property (
        (wr_force && reg_req_in.data[`SCE_BIT_STATUS]) |=> flags[`SCE_BIT_STATUS])
        else $error("force write did not set status flag");

    a_reset_clears: assert property (
        @(posedge clock_in) disable iff (1'b0) reset_in |=> flags == 4'h0)
        else $error("flags not zero after reset");

    a_power_event: assert property (
        (pins_sync.powered != live.powered) |=> flags[`SCE_BIT_POWER])
        else $error("power change not recorded");

    a_detect_frozen: assert property (
        identify_busy_in |=> $stable(live.detect_one) && $stable(live.detect_two))
        else $error("detect level moved during identification");

    a_cardbus_fall: assert property (
        (card_is_cardbus_in && !card_reset_in && !wr_force && !reset_release
         && !flags[`SCE_BIT_STATUS] && live.card_status && !pins_sync.card_status)
        |=> !flags[`SCE_BIT_STATUS])
        else $error("falling status edge set flag on cardbus card");

    a_b16_fall: assert property (
        (!card_is_cardbus_in && !card_reset_in && live.card_status
         && !pins_sync.card_status) |=> flags[`SCE_BIT_STATUS])
        else $error("falling status edge missed on 16-bit card");

    a_irq_masked: assert property (
        (enable == 4'h6 && flags == 4'h2)
        |=> status_change_interrupt_out == $past(interrupts_enable_in))
        else $error("interrupt gating by detect pair wrong");

    a_irq_partial_pair: assert property (
        (enable[2:1] != 2'h3 && !enable[3] && !enable[0])
        |=> !status_change_interrupt_out)
        else $error("interrupt raised with detect pair not enabled");

    a_mask_no_block: assert property (
        (enable == 4'h0 && force_set != 4'h0) |=> (flags & $past(force_set)) != 4'h0)
        else $error("masked event not latched");

    a_reserved_zero: assert property (
        reg_req_in.read && addr_hit(reg_req_in, `SCE_OFF_ENABLE)
        |=> reg_rvalid_out && reg_rdata_out[31:4] == 28'h0000000)
        else $error("reserved enable bits not zero");

    a_caps_hold: assert property (
        !insertion |=> $stable(caps))
        else $error("capability bits changed without insertion");

    a_live_read: assert property (
        reg_req_in.read && addr_hit(reg_req_in, `SCE_OFF_LIVE)
        |=> reg_rdata_out[3:0] == $past(live))
        else $error("live read does not show live levels");

    a_release_status: assert property (
        (reset_release && live.card_status) |=> flags[`SCE_BIT_STATUS])
        else $error("status not reported after card reset release");

endmodule

`default_nettype wire

/* File: design/sce_consts.svh */
`ifndef SCE_CONSTS_SVH
`define SCE_CONSTS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define SCE_OFF_FLAGS   8'h00
`define SCE_OFF_ENABLE  8'h04
`define SCE_OFF_LIVE    8'h08
`define SCE_OFF_FORCE   8'h0C

// ----------------------------------------
// field positions in flags, enable and live
// ----------------------------------------
`define SCE_BIT_POWER   3
`define SCE_BIT_DET2    2
`define SCE_BIT_DET1    1
`define SCE_BIT_STATUS  0
`define SCE_FIELD_W     4
`define SCE_BIT_CAP_Y   13
`define SCE_BIT_CAP_X   12
`define SCE_BIT_CAP_3   11
`define SCE_BIT_CAP_5   10
`define SCE_BIT_CBUS    5
`define SCE_BIT_B16     4

// ----------------------------------------
// reset and fixed values
// ----------------------------------------
`define SCE_FLAGS_RST   4'h0
`define SCE_ENABLE_RST  4'h0
`define SCE_CAPS_RST    6'h00
`define SCE_FORCE_RST   3'h0
`define SCE_PINS_RST    4'h6
`define SCE_SOCK_CAPS   2'h3
`define SCE_WORD_ZERO   32'h0000_0000
`define SCE_SYNC_STAGES 2

`endif

/* File: design/sce_pkg.sv */
`default_nettype none

package sce_pkg;

    // socket levels in flag bit order 3..0
    typedef struct packed {
        logic powered;
        logic detect_two;
        logic detect_one;
        logic card_status;
    } sce_pins_s;

    // card supply and type capabilities
    typedef struct packed {
        logic volt_y;
        logic volt_x;
        logic volt_3;
        logic volt_5;
        logic cardbus;
        logic bit16;
    } sce_caps_s;

    // register access request
    typedef struct packed {
        logic        write;
        logic        read;
        logic [7:0]  addr;
        logic [31:0] data;
    } sce_req_s;

endpackage

`default_nettype wire

/* File: design/sce_sync.sv */
`include "sce_consts.svh"
`default_nettype none

module sce_sync (
    // clock and reset
    input  wire logic             clock_in,
    input  wire logic             reset_in,
    // asynchronous socket pins
    input  wire sce_pkg::sce_pins_s pins_in,
    // synchronised levels
    output var  sce_pkg::sce_pins_s pins_out
);

    // ----------------------------------------
    // two-stage synchroniser
    // ----------------------------------------
    // stage one is read only by stage two; detect pins idle high (no card)
    sce_pkg::sce_pins_s stage_one;

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            stage_one <= `SCE_PINS_RST;
            pins_out  <= `SCE_PINS_RST;
        end else begin
            stage_one <= pins_in;
            pins_out  <= stage_one;
        end
    end

endmodule

`default_nettype wire

/* File: tb/sce_card_model.sv */
`default_nettype none

module sce_card_model (
    // commands from the bench
    input  wire logic               inserted_in,
    input  wire logic               powered_in,
    input  wire logic               status_in,
    input  wire sce_pkg::sce_caps_s caps_in,
    // socket side
    output var  sce_pkg::sce_pins_s pins_out,
    output var  sce_pkg::sce_caps_s caps_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // socket lines
    // ----------------------------------------
    // detect lines are pulled up, so an empty socket reads high
    always_comb begin
        pins_out.powered     = powered_in;
        pins_out.detect_two  = ~inserted_in;
        pins_out.detect_one  = ~inserted_in;
        pins_out.card_status = inserted_in & status_in;
        caps_out             = inserted_in ? caps_in : 6'h00;
    end
endmodule

`default_nettype wire

/* File: tb/tb_socket_status_change_events.sv */
`default_nettype none

module tb_socket_status_change_events;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // wiring
    // ----------------------------------------
    logic               clock_in = 1'b0;
    logic               reset_in = 1'b1;
    sce_pkg::sce_req_s  req      = '0;
    logic [31:0]        rdata;
    logic               rvalid;
    sce_pkg::sce_pins_s pins;
    sce_pkg::sce_caps_s caps_pin;
    logic [5:0]         caps     = 6'h00;
    logic               ins      = 1'b0;
    logic               pwr      = 1'b0;
    logic               sts      = 1'b0;
    logic               crst     = 1'b0;
    logic               busy     = 1'b0;
    logic               cbus     = 1'b1;
    logic               ie       = 1'b0;
    logic               irq;
    int                 mismatches  = 0;
    int                 checks_done = 0;

    always #2.5 clock_in = ~clock_in;

    sce_card_model i_sce_card_model (
        .inserted_in (ins),
        .powered_in  (pwr),
        .status_in   (sts),
        .caps_in     (caps),
        .pins_out    (pins),
        .caps_out    (caps_pin)
    );

    sce_top i_sce_top (
        .clock_in                    (clock_in),
        .reset_in                    (reset_in),
        .reg_req_in                  (req),
        .reg_rdata_out               (rdata),
        .reg_rvalid_out              (rvalid),
        .pins_in                     (pins),
        .card_caps_in                (caps_pin),
        .card_reset_in               (crst),
        .identify_busy_in            (busy),
        .card_is_cardbus_in          (cbus),
        .interrupts_enable_in        (ie),
        .status_change_interrupt_out (irq)
    );

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] live(input logic p, input logic in, input logic cs,
                                         input logic [5:0] cp);
        return {4'b0011, 14'h0000, cp[5:2], 4'h0, cp[1:0], p, ~in, ~in, cs};
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask

    // one strobe, held for exactly one sampling edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_in);
        req <= '{write: w, read: ~w, addr: a, data: d};
        @(posedge clock_in);
        req <= '0;
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        check({31'h0, rvalid}, 32'h0000_0001);
        check(rdata, exp);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset_values;
        rd(8'h00, 32'h0000_0000);
        rd(8'h04, 32'h0000_0000);
        rd(8'h08, live(1'b0, 1'b0, 1'b0, 6'h00));
    endtask

    task automatic t_reserved;
        wr(8'h04, 32'hFFFF_FFFF);
        rd(8'h04, 32'h0000_000F);
        wr(8'h04, 32'h0000_0000);
        wr(8'h08, 32'hFFFF_FFFF);
        rd(8'h08, live(1'b0, 1'b0, 1'b0, 6'h00));
        rd(8'h10, 32'h0000_0000);
        wr(8'h0C, 32'hFFFF_FFFF);
        rd(8'h00, 32'h0000_000F);
        rd(8'h08, live(1'b0, 1'b0, 1'b0, 6'h38));
        @(posedge clock_in);
        reset_in <= 1'b1;
        repeat (3) @(posedge clock_in);
        reset_in <= 1'b0;
        rd(8'h00, 32'h0000_0000);
    endtask

    task automatic t_power;
        @(posedge clock_in);
        pwr <= 1'b1;
        cyc(5);
        rd(8'h00, 32'h0000_0008);
        rd(8'h08, live(1'b1, 1'b0, 1'b0, 6'h00));
        wr(8'h00, 32'h0000_0000);
        rd(8'h00, 32'h0000_0008);
        wr(8'h00, 32'h0000_0008);
        rd(8'h00, 32'h0000_0000);
        @(posedge clock_in);
        pwr <= 1'b0;
        cyc(5);
        rd(8'h00, 32'h0000_0008);
        wr(8'h00, 32'h0000_0008);
    endtask

    task automatic t_insert;
        @(posedge clock_in);
        caps <= 6'h0E;
        ins  <= 1'b1;
        cyc(5);
        rd(8'h00, 32'h0000_0006);
        rd(8'h08, live(1'b0, 1'b1, 1'b0, 6'h0E));
        wr(8'h00, 32'h0000_0006);
        @(posedge clock_in);
        caps <= 6'h31;
        cyc(5);
        rd(8'h08, live(1'b0, 1'b1, 1'b0, 6'h0E));
        // removal while identification owns the detect lines
        @(posedge clock_in);
        busy <= 1'b1;
        ins  <= 1'b0;
        cyc(6);
        rd(8'h00, 32'h0000_0000);
        rd(8'h08, live(1'b0, 1'b1, 1'b0, 6'h0E));
        @(posedge clock_in);
        busy <= 1'b0;
        cyc(5);
        rd(8'h00, 32'h0000_0006);
        rd(8'h08, live(1'b0, 1'b0, 1'b0, 6'h0E));
        wr(8'h00, 32'h0000_0006);
        @(posedge clock_in);
        ins <= 1'b1;
        cyc(5);
        rd(8'h08, live(1'b0, 1'b1, 1'b0, 6'h31));
        wr(8'h00, 32'h0000_0006);
    endtask

    task automatic t_status;
        for (int cb = 1; cb >= 0; cb--) begin
            @(posedge clock_in);
            cbus <= cb[0];
            sts  <= 1'b1;
            cyc(5);
            rd(8'h00, 32'h0000_0001);
            wr(8'h00, 32'h0000_0001);
            @(posedge clock_in);
            sts <= 1'b0;
            cyc(5);
            rd(8'h00, {31'h0, ~cb[0]});
            wr(8'h00, 32'h0000_0001);
        end
        @(posedge clock_in);
        cbus <= 1'b1;
    endtask

    task automatic t_card_reset;
        @(posedge clock_in);
        crst <= 1'b1;
        sts  <= 1'b1;
        cyc(5);
        rd(8'h00, 32'h0000_0000);
        rd(8'h08, live(1'b0, 1'b1, 1'b1, 6'h31));
        @(posedge clock_in);
        crst <= 1'b0;
        cyc(3);
        rd(8'h00, 32'h0000_0007);
        wr(8'h00, 32'h0000_0007);
    endtask

    task automatic t_irq;
        logic [3:0] gate;
        // flags are cleared, then status is forced so it fires as soon as the global enable goes up
        wr(8'h00, 32'h0000_000F);
        wr(8'h04, 32'h0000_000F);
        wr(8'h0C, 32'h0000_0001);
        cyc(2);
        check({31'h0, irq}, 32'h0000_0000);
        @(posedge clock_in);
        ie <= 1'b1;
        cyc(2);
        check({31'h0, irq}, 32'h0000_0001);
        wr(8'h00, 32'h0000_000F);
        for (int f = 0; f < 4; f++) begin
            for (int e = 0; e < 16; e++) begin
                gate = {e[3], e[2] & e[1], e[2] & e[1], e[0]};
                wr(8'h04, e);
                wr(8'h0C, 32'h1 << f);
                cyc(2);
                check({31'h0, irq}, {31'h0, gate[f]});
                rd(8'h00, 32'h1 << f);
                wr(8'h00, 32'h0000_000F);
                cyc(2);
                check({31'h0, irq}, 32'h0000_0000);
            end
        end
        wr(8'h04, 32'h0000_0000);
    endtask

    // ----------------------------------------
    // run control
    // ----------------------------------------
    task automatic end_sim;
        $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // whole run is about a thousand cycles; this leaves wide margin
    initial begin
        #200000;
        mismatches++;
        end_sim();
    end

    initial begin
        repeat (12) @(posedge clock_in);
        reset_in <= 1'b0;
        t_reset_values();
        t_reserved();
        t_power();
        t_insert();
        t_status();
        t_card_reset();
        t_irq();
        end_sim();
    end
endmodule

`default_nettype wire
